// ===== include/fro_defines.vh
// fro_defines.vh: constants for the fir output rounding block.
// assumes inclusion by bare name from every design file of the block.
`ifndef FRO_DEFINES_VH
`define FRO_DEFINES_VH

// ------------------------------------------------------------
// datapath widths
// ------------------------------------------------------------
`define FRO_ACC_W       48
`define FRO_OUT_W       24
`define FRO_DROP_W      24

// ------------------------------------------------------------
// rounding constants, in accumulator lsbs
// ------------------------------------------------------------
`define FRO_K_ZERO      48'h000000000000
`define FRO_K_HALF      48'h000000800000
`define FRO_K_HALF_M1   48'h0000007FFFFF
`define FRO_LOW_ZERO    24'h000000
`define FRO_LOW_ONES    24'hFFFFFF

// ------------------------------------------------------------
// rounding modes
// ------------------------------------------------------------
`define FRO_MODE_W      3
`define FRO_M_TRUNC     3'h0
`define FRO_M_RPOS      3'h1
`define FRO_M_RNEG      3'h2
`define FRO_M_SYM_INF   3'h3
`define FRO_M_SYM_ZERO  3'h4
`define FRO_M_CONV_EVEN 3'h5
`define FRO_M_CONV_ODD  3'h6

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define FRO_ADR_W       8
`define FRO_REG_CTRL    8'h00
`define FRO_REG_GEOM    8'h04
`define FRO_REG_STAT    8'h08
`define FRO_REG_PLAN    8'h0C

// ------------------------------------------------------------
// control register fields and reset value
// ------------------------------------------------------------
`define FRO_CTRL_SPARE  3
`define FRO_CTRL_APPROX 4
`define FRO_CTRL_PMCD   5
`define FRO_CTRL_RST    6'h00

// ------------------------------------------------------------
// geometry register: taps [11:0], ratio [23:12], chans [27:24], sym [28]
// ------------------------------------------------------------
`define FRO_TAPS_RST    12'h008
`define FRO_RATIO_RST   12'h008
`define FRO_CHANS_RST   4'h1
`define FRO_COL_CAP     12'h020

// ------------------------------------------------------------
// status bits
// ------------------------------------------------------------
`define FRO_ST_BUSY     0
`define FRO_ST_STAGE    1
`define FRO_ST_NOCONV   2
`define FRO_ST_SPLIT    3
`define FRO_ST_SYMBIG   4

`endif

// ===== design/fro_acc.v
// fro_acc.v: accumulator of the fir mac engine with preload and carry-in.
// assumes one clock; the owner chooses load value, addend and carry-in.
`timescale 1ns/1ps
`default_nettype none
`include "fro_defines.vh"

module fro_acc (
    input  wire                     mclk_i,
    input  wire                     rst_i,
    input  wire                     en_i,
    input  wire                     load_i,
    input  wire [`FRO_ACC_W-1:0]    pre_i,
    input  wire [`FRO_ACC_W-1:0]    add_i,
    input  wire                     cin_i,
    output wire [`FRO_ACC_W-1:0]    acc_o,
    output wire                     sign_o
);

    reg  [`FRO_ACC_W-1:0] acc_r;
    wire [`FRO_ACC_W-1:0] base;
    wire [`FRO_ACC_W-1:0] acc_nxt;

    // ------------------------------------------------------------
    // accumulate
    // ------------------------------------------------------------
    // first term replaces the old sum, so the preload rides in for free
    assign base    = load_i ? pre_i : acc_r;
    assign acc_nxt = base + add_i + {{(`FRO_ACC_W-1){1'b0}}, cin_i};

    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            acc_r <= `FRO_K_ZERO;
        end else if (en_i) begin
            acc_r <= acc_nxt;
        end
    end

    assign acc_o  = acc_r;
    assign sign_o = acc_r[`FRO_ACC_W-1];

endmodule // fro_acc

`default_nettype wire

// ===== design/fro_round.v
// fro_round.v: final reduction stage; optional extra rounding adder,
// convergent midpoint detection and lsb forcing, registered output.
// assumes acc_i is stable in the cycle that in_valid_i is high.
`timescale 1ns/1ps
`default_nettype none
`include "fro_defines.vh"

module fro_round (
    input  wire                     mclk_i,
    input  wire                     rst_i,
    input  wire                     in_valid_i,
    input  wire [`FRO_ACC_W-1:0]    acc_i,
    input  wire                     stage_en_i,
    input  wire [`FRO_ACC_W-1:0]    k_i,
    input  wire                     to_zero_i,
    input  wire                     conv_i,
    input  wire                     odd_i,
    output wire [`FRO_OUT_W-1:0]    y_o,
    output wire                     valid_o
);

    reg  [`FRO_OUT_W-1:0] y_r;
    reg                   valid_r;
    reg  [`FRO_OUT_W-1:0] y_nxt;
    wire                  sign;
    wire                  cin;
    wire [`FRO_ACC_W-1:0] sum;
    wire                  mid;

    // ------------------------------------------------------------
    // exact symmetric add on the final sign
    // ------------------------------------------------------------
    assign sign = acc_i[`FRO_ACC_W-1];
    assign cin  = stage_en_i & (to_zero_i ? sign : ~sign);
    assign sum  = acc_i + (stage_en_i ? k_i : `FRO_K_ZERO)
                + {{(`FRO_ACC_W-1){1'b0}}, cin};

    // ------------------------------------------------------------
    // midpoint pattern and lsb forcing
    // ------------------------------------------------------------
    assign mid = (sum[`FRO_DROP_W-1:0] == (odd_i ? `FRO_LOW_ONES : `FRO_LOW_ZERO));

    always @* begin
        y_nxt = sum[`FRO_ACC_W-1:`FRO_DROP_W];
        if (conv_i && mid) begin
            y_nxt[0] = odd_i;
        end
    end

    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            y_r     <= `FRO_LOW_ZERO;
            valid_r <= 1'b0;
        end else begin
            valid_r <= in_valid_i;
            if (in_valid_i) begin
                y_r <= y_nxt;
            end
        end
    end

    assign y_o     = y_r;
    assign valid_o = valid_r;

endmodule // fro_round

`default_nettype wire

// ===== design/fro_top.v
// fro_top.v: fir mac accumulation with selectable output rounding,
// wishbone classic register slave and build-plan status.
// assumes products arrive in tap order, first and last marked, one clock.
//
// Design decisions made here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fro_defines.vh"

module fro_top #(
    parameter HAS_PATDET = 1
) (
    input  wire                     mclk_i,
    input  wire                     rst_i,
    input  wire                     wb_cyc_i,
    input  wire                     wb_stb_i,
    input  wire                     wb_we_i,
    input  wire [`FRO_ADR_W-1:0]    wb_adr_i,
    input  wire [3:0]               wb_sel_i,
    input  wire [31:0]              wb_dat_i,
    output wire [31:0]              wb_dat_o,
    output wire                     wb_ack_o,
    input  wire                     term_valid_i,
    input  wire                     term_first_i,
    input  wire                     term_last_i,
    input  wire [`FRO_ACC_W-1:0]    term_i,
    output wire                     term_ready_o,
    output wire [`FRO_OUT_W-1:0]    y_o,
    output wire                     y_valid_o
);

    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    localparam [2:0] ST_IDLE  = 3'h1;
    localparam [2:0] ST_ACC   = 3'h2;
    localparam [2:0] ST_EXTRA = 3'h4;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    reg  [2:0]              state_r;
    reg  [2:0]              state_nxt;
    reg                     ready_r;
    reg                     done_r;
    reg  [5:0]              ctrl_r;
    reg  [28:0]             geom_r;
    reg  [31:0]             dat_r;
    reg                     ack_r;
    reg  [2:0]              mode_r;
    reg                     spare_r;
    reg                     approx_r;
    reg                     stage_r;
    reg  [11:0]             budget_r;
    reg  [11:0]             mults_r;
    reg                     split_r;
    reg                     symbig_r;
    reg  [2:0]              mode_eff;
    reg  [`FRO_ACC_W-1:0]   k_sel;
    reg                     acc_en;
    reg                     acc_load;
    reg  [`FRO_ACC_W-1:0]   acc_add;
    reg                     acc_cin;
    reg  [31:0]             rd_nxt;
    wire [`FRO_ACC_W-1:0]   acc_val;
    wire                    acc_sign;
    wire                    take;
    wire                    is_sym;
    wire                    use_spare;
    wire                    use_approx;
    wire                    use_stage;
    wire                    to_zero;
    wire                    conv_ok;
    wire [11:0]             taps;
    wire [11:0]             ratio;
    wire [3:0]              chans;
    wire                    geom_sym;
    wire [11:0]             chans_div;
    wire [11:0]             budget_nxt;
    wire [11:0]             mults_nxt;
    wire                    wb_req;
    wire                    wb_wr;
    wire [31:0]             geom_wr;

    // ------------------------------------------------------------
    // effective mode
    // ------------------------------------------------------------
    // without pattern hardware convergent falls back to plain truncation
    assign conv_ok = (HAS_PATDET != 0);

    always @* begin
        mode_eff = ctrl_r[2:0];
        if (ctrl_r[2:0] == 3'h7 || (!conv_ok && (ctrl_r[2:0] == `FRO_M_CONV_EVEN
                || ctrl_r[2:0] == `FRO_M_CONV_ODD))) begin
            mode_eff = `FRO_M_TRUNC;
        end
    end

    // ------------------------------------------------------------
    // where the rounding happens
    // ------------------------------------------------------------
    assign is_sym     = (mode_eff == `FRO_M_SYM_INF) || (mode_eff == `FRO_M_SYM_ZERO);
    assign use_spare  = is_sym & ctrl_r[`FRO_CTRL_SPARE];
    assign use_approx = is_sym & ~ctrl_r[`FRO_CTRL_SPARE] & ctrl_r[`FRO_CTRL_APPROX]
                      & ~ctrl_r[`FRO_CTRL_PMCD];
    assign use_stage  = is_sym & ~use_spare & ~use_approx;
    assign to_zero    = (mode_r == `FRO_M_SYM_ZERO);

    // ------------------------------------------------------------
    // rounding constant per mode
    // ------------------------------------------------------------
    always @* begin
        case (mode_r)
            `FRO_M_RPOS:      k_sel = `FRO_K_HALF;
            `FRO_M_CONV_EVEN: k_sel = `FRO_K_HALF;
            `FRO_M_RNEG:      k_sel = `FRO_K_HALF_M1;
            `FRO_M_SYM_INF:   k_sel = `FRO_K_HALF_M1;
            `FRO_M_SYM_ZERO:  k_sel = `FRO_K_HALF_M1;
            `FRO_M_CONV_ODD:  k_sel = `FRO_K_HALF_M1;
            default:          k_sel = `FRO_K_ZERO;
        endcase
    end

    // ------------------------------------------------------------
    // frame setup snapshot
    // ------------------------------------------------------------
    // taken on the first term so a mid-frame write cannot split a sum
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_r   <= `FRO_M_TRUNC;
            spare_r  <= 1'b0;
            approx_r <= 1'b0;
            stage_r  <= 1'b0;
        end else if (take && term_first_i) begin
            mode_r   <= mode_eff;
            spare_r  <= use_spare;
            approx_r <= use_approx;
            stage_r  <= use_stage;
        end
    end

    // ------------------------------------------------------------
    // accumulation control
    // ------------------------------------------------------------
    assign take = term_valid_i & ready_r;

    always @* begin
        acc_en   = 1'b0;
        acc_load = 1'b0;
        acc_add  = term_i;
        acc_cin  = 1'b0;
        if (state_r == ST_EXTRA) begin
            acc_en  = 1'b1;
            acc_add = k_sel;
            acc_cin = to_zero ? acc_sign : ~acc_sign;
        end else if (take) begin
            acc_en   = 1'b1;
            acc_load = term_first_i;
            // sum before this term is the penultimate result
            if (approx_r && term_last_i && !term_first_i) begin
                acc_cin = to_zero ? acc_sign : ~acc_sign;
            end
        end
    end

    fro_acc u_acc (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .en_i   (acc_en),
        .load_i (acc_load),
        .pre_i  (use_spare || use_stage ? `FRO_K_ZERO : k_sel_first(mode_eff)),
        .add_i  (acc_add),
        .cin_i  (acc_cin),
        .acc_o  (acc_val),
        .sign_o (acc_sign)
    );

    // constant for the frame being opened, before mode_r catches up
    function [`FRO_ACC_W-1:0] k_sel_first;
        input [2:0] m;
        begin
            case (m)
                `FRO_M_RPOS:      k_sel_first = `FRO_K_HALF;
                `FRO_M_CONV_EVEN: k_sel_first = `FRO_K_HALF;
                `FRO_M_TRUNC:     k_sel_first = `FRO_K_ZERO;
                default:          k_sel_first = `FRO_K_HALF_M1;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (take && term_first_i) begin
                    state_nxt = term_last_i ? (use_spare ? ST_EXTRA : ST_IDLE) : ST_ACC;
                end
            end
            ST_ACC: begin
                if (take && term_last_i) begin
                    state_nxt = spare_r ? ST_EXTRA : ST_IDLE;
                end
            end
            ST_EXTRA: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            ready_r <= 1'b0;
            done_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            ready_r <= (state_nxt != ST_EXTRA);
            done_r  <= (state_r == ST_EXTRA)
                     | (take & term_last_i & (state_nxt != ST_EXTRA));
        end
    end

    // ------------------------------------------------------------
    // output stage
    // ------------------------------------------------------------
    fro_round u_round (
        .mclk_i     (mclk_i),
        .rst_i      (rst_i),
        .in_valid_i (done_r),
        .acc_i      (acc_val),
        .stage_en_i (stage_r),
        .k_i        (k_sel),
        .to_zero_i  (to_zero),
        .conv_i     ((mode_r == `FRO_M_CONV_EVEN) || (mode_r == `FRO_M_CONV_ODD)),
        .odd_i      (mode_r == `FRO_M_CONV_ODD),
        .y_o        (y_o),
        .valid_o    (y_valid_o)
    );

    // ------------------------------------------------------------
    // build plan: cycle budget and multiplier columns
    // ------------------------------------------------------------
    assign taps      = geom_r[11:0];
    assign ratio     = geom_r[23:12];
    assign chans     = geom_r[27:24];
    assign geom_sym  = geom_r[28];
    assign chans_div = (chans == 4'h0) ? 12'h001 : {8'h00, chans};
    assign budget_nxt = ratio / chans_div;
    // zero budget means no time sharing: one multiplier per tap
    assign mults_nxt = (budget_nxt == 12'h000) ? taps
                     : (taps + budget_nxt - 12'h001) / budget_nxt;

    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            budget_r <= 12'h000;
            mults_r  <= 12'h000;
            split_r  <= 1'b0;
            symbig_r <= 1'b0;
        end else begin
            budget_r <= budget_nxt;
            mults_r  <= mults_nxt;
            split_r  <= (mults_nxt > `FRO_COL_CAP) & ~geom_sym;
            symbig_r <= (mults_nxt > `FRO_COL_CAP) & geom_sym;
        end
    end

    // ------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------
    // answer one cycle after the strobe; ack drops for a cycle after
    assign wb_req = wb_cyc_i & wb_stb_i & ~ack_r;
    assign wb_wr  = wb_req & wb_we_i;

    function [31:0] merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  sel;
        integer      i;
        begin
            merge = old_v;
            for (i = 0; i < 4; i = i + 1) begin
                if (sel[i]) begin
                    merge[i*8 +: 8] = new_v[i*8 +: 8];
                end
            end
        end
    endfunction

    assign geom_wr = merge({3'h0, geom_r}, wb_dat_i, wb_sel_i);

    always @* begin
        case (wb_adr_i)
            `FRO_REG_CTRL: rd_nxt = {26'h0, ctrl_r};
            `FRO_REG_GEOM: rd_nxt = {3'h0, geom_r};
            `FRO_REG_STAT: rd_nxt = {27'h0, symbig_r, split_r, ~conv_ok,
                                     stage_r, ~state_r[0]};
            `FRO_REG_PLAN: rd_nxt = {4'h0, mults_r, 4'h0, budget_r};
            default:       rd_nxt = 32'h00000000;
        endcase
    end

    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_r  <= 1'b0;
            dat_r  <= 32'h00000000;
            ctrl_r <= `FRO_CTRL_RST;
            geom_r <= {1'b0, `FRO_CHANS_RST, `FRO_RATIO_RST, `FRO_TAPS_RST};
        end else begin
            ack_r <= wb_req;
            if (wb_req && !wb_we_i) begin
                dat_r <= rd_nxt;
            end
            if (wb_wr && wb_adr_i == `FRO_REG_CTRL) begin
                ctrl_r <= wb_sel_i[0] ? wb_dat_i[5:0] : ctrl_r;
            end
            if (wb_wr && wb_adr_i == `FRO_REG_GEOM) begin
                geom_r <= geom_wr[28:0];
            end
        end
    end

    assign wb_ack_o     = ack_r;
    assign wb_dat_o     = dat_r;
    assign term_ready_o = ready_r;

endmodule // fro_top

`default_nettype wire

// ===== tb/fro_top_properties.sv
// fro_top_properties.sv: port-level checks of the rounding block.
// assumes binding onto fro_top; one clock, async active-high reset.
`timescale 1ns/1ps
`default_nettype none
`include "fro_defines.vh"
module fro_top_props (
    input wire logic                  mclk_i,
    input wire logic                  rst_i,
    input wire logic                  wb_cyc_i,
    input wire logic                  wb_stb_i,
    input wire logic                  wb_we_i,
    input wire logic [`FRO_ADR_W-1:0] wb_adr_i,
    input wire logic [31:0]           wb_dat_o,
    input wire logic                  wb_ack_o,
    input wire logic                  term_valid_i,
    input wire logic                  term_last_i,
    input wire logic                  term_ready_o,
    input wire logic [`FRO_OUT_W-1:0] y_o,
    input wire logic                  y_valid_o
);
    // ------------------------------------------------------------
    // bus and stream relations
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    wire lt = term_valid_i & term_ready_o & term_last_i;
    sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_last; term_valid_i && term_ready_o && term_last_i; endsequence
    property p_ack; s_req |=> wb_ack_o; endproperty
    property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
    property p_ackc; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
    property p_hole;
        wb_ack_o && $past(!wb_we_i && wb_adr_i > `FRO_REG_PLAN) |-> wb_dat_o == 32'h0;
    endproperty
    property p_res; s_last |-> ##[2:3] y_valid_o; endproperty
    property p_src; y_valid_o |-> $past(lt, 2) || $past(lt, 3); endproperty
    property p_hold; !y_valid_o |-> $stable(y_o); endproperty
    property p_gap; $fell(term_ready_o) |=> term_ready_o; endproperty
    a_ack: assert property (p_ack) else $error("ack not given");
    a_ack1: assert property (p_ack1) else $error("ack longer than one cycle");
    a_ackc: assert property (p_ackc) else $error("ack without request");
    a_hole: assert property (p_hole) else $error("unmapped read not zero");
    a_res: assert property (p_res) else $error("result late or missing");
    a_src: assert property (p_src) else $error("result without last product");
    a_hold: assert property (p_hold) else $error("output moved between results");
    a_gap: assert property (p_gap) else $error("refusal longer than one cycle");
endmodule // fro_top_props
`default_nettype wire

// ===== tb/fro_src_model.sv
// fro_src_model.sv: product source ahead of the rounding block.
// assumes ready_i is registered; each product held until taken.
`timescale 1ns/1ps
`default_nettype none
module fro_src (
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic        go_i,
    input  wire logic [7:0]  n_i,
    input  wire logic [47:0] a_i,
    input  wire logic [47:0] b_i,
    input  wire logic        ready_i,
    output logic             valid_o,
    output logic             first_o,
    output logic             last_o,
    output logic      [47:0] term_o
);
    logic [7:0] k_r;
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            k_r     <= 8'h00;
            valid_o <= 1'b0;
            first_o <= 1'b0;
            last_o  <= 1'b0;
            term_o  <= 48'h0;
        end else if (valid_o && !ready_i) begin
            // refused: hold the product
        end else if (k_r != 8'h00) begin
            valid_o <= 1'b1;
            first_o <= (k_r == n_i);
            last_o  <= (k_r == 8'h01);
            term_o  <= (k_r == n_i) ? a_i : (k_r == 8'h01) ? b_i : 48'h0;
            k_r     <= k_r - 8'h01;
        end else begin
            valid_o <= 1'b0;
            first_o <= 1'b0;
            last_o  <= 1'b0;
            term_o  <= ~term_o; // idle data toggles, never stale
            if (go_i) k_r <= n_i;
        end
    end
endmodule // fro_src
`default_nettype wire

// ===== tb/tb_top.sv
// tb_top.sv: self-checking bench of fro_top.
// assumes fro_src feeds products; registers over wishbone classic.
`timescale 1ns/1ps
`default_nettype none
`include "fro_defines.vh"
module tb_top;
    localparam logic [47:0] POS = 48'h000002800000;
    localparam logic [47:0] NEG = 48'hFFFFFD800000;
    // {negative, mode, expected}: midpoints expose each rounding direction
    localparam logic [27:0] ROWS [16] = '{28'h0000002, 28'h1000003, 28'h2000002,
        28'h3000003, 28'h4000002, 28'h5000002, 28'h6000003, 28'h7000002, 28'h8FFFFFD,
        28'h9FFFFFE, 28'hAFFFFFD, 28'hBFFFFFD, 28'hCFFFFFE, 28'hDFFFFFE, 28'hEFFFFFD,
        28'hFFFFFFD};
    logic        mclk_i = 0, rst_i = 1, req = 0, we = 0, go = 0, got = 0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wd = 32'h0, rd;
    logic [47:0] a = 48'h0, b = 48'h0;
    logic [23:0] yq;
    wire  [31:0] wb_q;
    wire  [47:0] term;
    wire  [23:0] y;
    wire         ack, tv, tf, tl, tr, yv;
    // lat0: edges from taking the last product to seeing the result
    int          error_cnt = 0, compares = 0, cnt = 0, lat = 0, lat0 = 2, t;
    always #25 mclk_i = ~mclk_i;
    fro_top dut (.mclk_i(mclk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(wb_q),
        .wb_ack_o(ack), .term_valid_i(tv), .term_first_i(tf), .term_last_i(tl),
        .term_i(term), .term_ready_o(tr), .y_o(y), .y_valid_o(yv));
    fro_src src (.mclk_i(mclk_i), .rst_i(rst_i), .go_i(go), .n_i(8'h03), .a_i(a),
        .b_i(b), .ready_i(tr), .valid_o(tv), .first_o(tf), .last_o(tl), .term_o(term));
    always @(posedge mclk_i) begin
        cnt <= (tv & tr & tl) ? 1 : cnt + 1;
        if (yv === 1'b1) begin
            yq  <= y;
            lat <= cnt;
            got <= 1'b1;
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] ad, input logic [3:0] s,
                      input logic [31:0] d);
        @(posedge mclk_i);
        req <= 1'b1;
        we  <= w;
        adr <= ad;
        sel <= s;
        wd  <= d;
        t = 0;
        do begin
            @(posedge mclk_i);
            t++;
        end while (ack !== 1'b1 && t < 20);
        if (ack !== 1'b1) error_cnt++;
        rd  = wb_q;
        req <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] ad, input logic [31:0] e);
        wb(1'b0, ad, 4'hF, 32'h0);
        chk(rd, e);
    endtask
    // mode and path bits written first; rounding mode only changes between sums
    task automatic run(input logic [47:0] x, input logic [47:0] z, input logic [5:0] c);
        wb(1'b1, `FRO_REG_CTRL, 4'hF, {26'h0, c});
        @(posedge mclk_i);
        a   <= x;
        b   <= z;
        go  <= 1'b1;
        got <= 1'b0;
        @(posedge mclk_i);
        go  <= 1'b0;
        t = 0;
        while (got !== 1'b1 && t < 40) begin
            @(posedge mclk_i);
            t++;
        end
        if (got !== 1'b1) error_cnt++;
    endtask
    task automatic finish_test();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge mclk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        rchk(`FRO_REG_CTRL, 32'h0);
        rchk(`FRO_REG_GEOM, 32'h01008008);
        rchk(`FRO_REG_STAT, 32'h0);
        rchk(`FRO_REG_PLAN, 32'h00010008);
        wb(1'b1, 8'h10, 4'hF, 32'hFFFFFFFF);
        rchk(8'h10, 32'h0);
        wb(1'b1, `FRO_REG_STAT, 4'hF, 32'hFFFFFFFF);
        rchk(`FRO_REG_STAT, 32'h0);
        wb(1'b1, `FRO_REG_GEOM, 4'h1, 32'hFFFFFFFF);
        rchk(`FRO_REG_GEOM, 32'h010080FF);
        wb(1'b1, `FRO_REG_GEOM, 4'hF, 32'h04004060);
        rchk(`FRO_REG_PLAN, 32'h00600001);
        rchk(`FRO_REG_STAT, 32'h00000008);
        wb(1'b1, `FRO_REG_GEOM, 4'hF, 32'h14004060);
        rchk(`FRO_REG_STAT, 32'h00000010);
        wb(1'b1, `FRO_REG_GEOM, 4'hF, 32'h01008008);
        rchk(`FRO_REG_STAT, 32'h0);
        for (int i = 0; i < 16; i++) begin
            run(ROWS[i][27] ? NEG : POS, 48'h0, {3'h0, ROWS[i][26:24]});
            chk(yq, ROWS[i][23:0]);
            chk(lat, lat0);
        end
        // code 7 truncates: a preloaded constant would carry this sum up
        run(48'h000002800001, 48'h0, 6'h07);
        chk(yq, 32'h00000002);
        run(NEG, 48'h0, 6'h0C);
        chk(yq, 32'h00FFFFFE);
        chk(lat, lat0 + 1);
        run(48'h000001800000, 48'hFFFFFC000000, 6'h14);
        chk(yq, 32'h00FFFFFD);
        run(48'h000001800000, 48'hFFFFFC000000, 6'h34);
        chk(yq, 32'h00FFFFFE);
        run(48'h7FFFFF800000, 48'h0, 6'h04);
        chk(yq, 32'h007FFFFF);
        // mid-run reset must bring the control word back
        rst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        rchk(`FRO_REG_CTRL, 32'h0);
        finish_test();
    end
    initial begin
        #500000;
        error_cnt++;
        finish_test();
    end
endmodule // tb_top
bind fro_top fro_top_props u_props (.mclk_i(mclk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .term_valid_i(term_valid_i), .term_last_i(term_last_i),
    .term_ready_o(term_ready_o), .y_o(y_o), .y_valid_o(y_valid_o));
`default_nettype wire
